// [verilog/bfx_pkg.sv]
// package: opcodes, status bit layout, register map and carriers of the bit and flag unit
package bfx_pkg;

	// ****************************************
	// status register bit positions
	// ****************************************
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;
	localparam int SR_T = 6;
	localparam int SR_I = 7;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// ****************************************
	// register map of the software port
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_INFO = 8'h01;
	localparam logic [7:0] ADDR_IO_BASE = 8'h10;
	localparam int INFO_BUSY = 0;
	localparam int INFO_COLLIDE = 1;
	localparam int IO_AW = 4;

	// ****************************************
	// timing
	// ****************************************
	localparam int IO_BIT_CYCLES = 2;
	localparam int SIMPLE_CYCLES = 1;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [4:0] {
		nop_op = 5'h00,
		sleep_op = 5'h01,
		watchdog_kick_op = 5'h02,
		break_op = 5'h03,
		set_io_bit_op = 5'h04,
		clear_io_bit_op = 5'h05,
		logical_left_shift_op = 5'h06,
		logical_right_shift_op = 5'h07,
		arith_right_shift_op = 5'h08,
		rotate_left_carry_op = 5'h09,
		rotate_right_carry_op = 5'h0a,
		swap_nibbles_op = 5'h0b,
		bit_to_transfer_op = 5'h0c,
		transfer_to_bit_op = 5'h0d,
		indexed_flag_set_op = 5'h0e,
		indexed_flag_clear_op = 5'h0f,
		carry_set_op = 5'h10,
		carry_clear_op = 5'h11,
		negative_set_op = 5'h12,
		negative_clear_op = 5'h13,
		zero_set_op = 5'h14,
		zero_clear_op = 5'h15,
		half_carry_set_op = 5'h16,
		half_carry_clear_op = 5'h17,
		transfer_set_op = 5'h18,
		transfer_clear_op = 5'h19,
		irq_global_on_op = 5'h1a,
		irq_global_off_op = 5'h1b,
		signed_flag_set_op = 5'h1c,
		signed_flag_clear_op = 5'h1d,
		overflow_set_op = 5'h1e,
		overflow_clear_op = 5'h1f
	} bfx_op_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_rmw = 2'b01
	} bfx_fsm_t;

	typedef struct packed {
		logic valid;
		bfx_op_t op;
		logic [2:0] bsel;
		logic [IO_AW-1:0] io_addr;
		logic [7:0] opd;
	} bfx_ins_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} bfx_res_t;

	typedef struct packed {
		logic sleep;
		logic wdt_kick;
		logic brk;
	} bfx_pulse_t;

	typedef struct packed {
		logic hit;
		logic val;
		logic [2:0] idx;
	} bfx_flag_t;

	typedef struct packed {
		bfx_fsm_t fsm;
		logic ready;
		logic [7:0] status;
		bfx_res_t res;
		bfx_pulse_t pulse;
		logic [IO_AW-1:0] rmw_addr;
		logic [2:0] rmw_bsel;
		logic rmw_set;
		logic collide;
	} bfx_state_t;

endpackage

// [verilog/bfx_io_mem.sv]
// io register space: one write port, two read ports with registered read data
module bfx_io_mem #(
	parameter int AW = 4,
	parameter int W = 8
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [W-1:0] wr_data_i,
	input wire logic [AW-1:0] a_addr_i,
	output logic [W-1:0] a_q_o,
	input wire logic b_rd_en_i,
	input wire logic b_sel_mem_i,
	input wire logic [AW-1:0] b_addr_i,
	input wire logic [W-1:0] b_alt_i,
	output logic [W-1:0] b_q_o
);

	logic [W-1:0] mem [0:(1<<AW)-1];

	// reads return the word as it stood before a same-cycle write
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < (1 << AW); i++)
				mem[i] <= '0;
			a_q_o <= '0;
			b_q_o <= '0;
		end
		else
		begin
			if (wr_en_i)
				mem[wr_addr_i] <= wr_data_i;
			a_q_o <= mem[a_addr_i];
			// software read data stand only in the cycle after the strobe
			if (b_rd_en_i)
				b_q_o <= b_sel_mem_i ? mem[b_addr_i] : b_alt_i;
			else
				b_q_o <= '0;
		end
	end

endmodule

// [verilog/bfx_exec_unit.sv]
// bit, shift, rotate, flag and control execution unit with its status register and io bit space
//
// Behaviour
// - io bit set/clear: two cycles, no flags
// - shifts: one cycle, update Z C N V
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - bit store copies register bit into T
// - bit load copies T into register bit
// - dedicated and indexed single flag set/clear
// - signed flag set/clear, single cycle
// - overflow flag set/clear, single cycle
// - sleep and no-op: one cycle, no flags
// - watchdog kick: one cycle, restart pulse
// - break: debug pulse only, no flags
//
// Local design decisions: the plain strobed port and the placing of the registers.
module bfx_exec_unit (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire bfx_pkg::bfx_ins_t ins_i,
	output logic ready_o,
	output bfx_pkg::bfx_res_t res_o,
	output logic [7:0] status_o,
	output bfx_pkg::bfx_pulse_t pulse_o,
	input wire logic [7:0] bus_addr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [7:0] bus_rdata_o
);
	import bfx_pkg::*;

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic is_io(input logic [7:0] a);
		is_io = (a[7:IO_AW] == ADDR_IO_BASE[7:IO_AW]);
	endfunction

	// maps each dedicated flag instruction onto a status bit and a value
	function automatic bfx_flag_t flag_target(input bfx_op_t op);
		bfx_flag_t f;
		f.hit = 1'b1;
		f.val = ~op[0];
		case (op)
			carry_set_op, carry_clear_op: f.idx = 3'(SR_C);
			negative_set_op, negative_clear_op: f.idx = 3'(SR_N);
			zero_set_op, zero_clear_op: f.idx = 3'(SR_Z);
			half_carry_set_op, half_carry_clear_op: f.idx = 3'(SR_H);
			transfer_set_op, transfer_clear_op: f.idx = 3'(SR_T);
			irq_global_on_op, irq_global_off_op: f.idx = 3'(SR_I);
			signed_flag_set_op, signed_flag_clear_op: f.idx = 3'(SR_S);
			overflow_set_op, overflow_clear_op: f.idx = 3'(SR_V);
			default:
			begin
				f.hit = 1'b0;
				f.idx = 3'h0;
			end
		endcase
		flag_target = f;
	endfunction

	// ****************************************
	// state and memory
	// ****************************************
	bfx_state_t s_reg;
	bfx_state_t s_next;
	logic accept;
	logic mem_wr_en;
	logic [IO_AW-1:0] mem_wr_addr;
	logic [7:0] mem_wr_data;
	logic [7:0] mem_a_q;
	logic [7:0] rd_alt;
	logic [7:0] sh_res;
	logic sh_c;
	logic [7:0] st;
	logic [7:0] bmask;
	bfx_flag_t ft;

	bfx_io_mem #(
		.AW(IO_AW),
		.W(8)
	) u_io_mem (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(mem_wr_en),
		.wr_addr_i(mem_wr_addr),
		.wr_data_i(mem_wr_data),
		.a_addr_i(ins_i.io_addr),
		.a_q_o(mem_a_q),
		.b_rd_en_i(bus_rd_i),
		.b_sel_mem_i(is_io(bus_addr_i)),
		.b_addr_i(bus_addr_i[IO_AW-1:0]),
		.b_alt_i(rd_alt),
		.b_q_o(bus_rdata_o)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		s_next = s_reg;
		s_next.res.valid = 1'b0;
		s_next.pulse = '0;
		accept = ins_i.valid && s_reg.ready;
		st = s_reg.status;
		sh_res = 8'h00;
		sh_c = 1'b0;
		bmask = 8'(8'h01 << s_reg.rmw_bsel);
		ft = flag_target(ins_i.op);
		mem_wr_en = 1'b0;
		mem_wr_addr = bus_addr_i[IO_AW-1:0];
		mem_wr_data = bus_wdata_i;

		// software read of the non-memory registers
		rd_alt = 8'h00;
		if (bus_addr_i == ADDR_STATUS)
			rd_alt = s_reg.status;
		else if (bus_addr_i == ADDR_INFO)
		begin
			rd_alt[INFO_BUSY] = (s_reg.fsm == st_rmw);
			rd_alt[INFO_COLLIDE] = s_reg.collide;
		end

		// software writes; an instruction that writes status in the same cycle overrides a status write
		if (bus_wr_i)
		begin
			if (bus_addr_i == ADDR_STATUS)
				s_next.status = bus_wdata_i;
			else if (bus_addr_i == ADDR_INFO && bus_wdata_i[INFO_COLLIDE])
				s_next.collide = 1'b0;
			else if (is_io(bus_addr_i))
				mem_wr_en = 1'b1;
		end

		// shifter datapath
		case (ins_i.op)
			logical_left_shift_op:
			begin
				sh_res = {ins_i.opd[6:0], 1'b0};
				sh_c = ins_i.opd[7];
			end
			logical_right_shift_op:
			begin
				sh_res = {1'b0, ins_i.opd[7:1]};
				sh_c = ins_i.opd[0];
			end
			arith_right_shift_op:
			begin
				sh_res = {ins_i.opd[7], ins_i.opd[7:1]};
				sh_c = ins_i.opd[0];
			end
			rotate_left_carry_op:
			begin
				sh_res = {ins_i.opd[6:0], s_reg.status[SR_C]};
				sh_c = ins_i.opd[7];
			end
			rotate_right_carry_op:
			begin
				sh_res = {s_reg.status[SR_C], ins_i.opd[7:1]};
				sh_c = ins_i.opd[0];
			end
			default:
			begin
				sh_res = 8'h00;
				sh_c = 1'b0;
			end
		endcase

		case (s_reg.fsm)
			st_idle:
			begin
				if (accept)
				begin
					// flag updates start from the held status so bits not named stay put
					case (ins_i.op)
						set_io_bit_op, clear_io_bit_op:
						begin
							s_next.fsm = st_rmw;
							s_next.ready = 1'b0;
							s_next.rmw_addr = ins_i.io_addr;
							s_next.rmw_bsel = ins_i.bsel;
							s_next.rmw_set = (ins_i.op == set_io_bit_op);
						end
						logical_left_shift_op, logical_right_shift_op, arith_right_shift_op,
						rotate_left_carry_op, rotate_right_carry_op:
						begin
							st[SR_C] = sh_c;
							st[SR_Z] = (sh_res == 8'h00);
							st[SR_N] = sh_res[7];
							st[SR_V] = sh_res[7] ^ sh_c;
							s_next.status = st;
							s_next.res.valid = 1'b1;
							s_next.res.data = sh_res;
						end
						swap_nibbles_op:
						begin
							s_next.res.valid = 1'b1;
							s_next.res.data = {ins_i.opd[3:0], ins_i.opd[7:4]};
						end
						bit_to_transfer_op:
						begin
							st[SR_T] = ins_i.opd[ins_i.bsel];
							s_next.status = st;
						end
						transfer_to_bit_op:
						begin
							s_next.res.valid = 1'b1;
							s_next.res.data = ins_i.opd;
							s_next.res.data[ins_i.bsel] = s_reg.status[SR_T];
						end
						indexed_flag_set_op, indexed_flag_clear_op:
						begin
							st[ins_i.bsel] = (ins_i.op == indexed_flag_set_op);
							s_next.status = st;
						end
						sleep_op:
							s_next.pulse.sleep = 1'b1;
						watchdog_kick_op:
							s_next.pulse.wdt_kick = 1'b1;
						break_op:
							s_next.pulse.brk = 1'b1;
						nop_op:
							s_next.res.valid = 1'b0;
						default:
						begin
							// dedicated flag ops, signed and overflow among them
							if (ft.hit)
							begin
								st[ft.idx] = ft.val;
								s_next.status = st;
							end
						end
					endcase
				end
			end
			st_rmw:
			begin
				// second cycle: write back the word read in the issue cycle
				mem_wr_en = 1'b1;
				mem_wr_addr = s_reg.rmw_addr;
				mem_wr_data = s_reg.rmw_set ? (mem_a_q | bmask) : (mem_a_q & ~bmask);
				// a software io write in this cycle is dropped; the sticky bit tells why
				if (bus_wr_i && is_io(bus_addr_i))
					s_next.collide = 1'b1;
				s_next.fsm = st_idle;
				s_next.ready = 1'b1;
			end
			default:
			begin
				s_next.fsm = st_idle;
				s_next.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			s_reg <= '0;
			s_reg.fsm <= st_idle;
			s_reg.ready <= 1'b1;
			s_reg.status <= STATUS_RST;
		end
		else
			s_reg <= s_next;
	end

	assign ready_o = s_reg.ready;
	assign res_o = s_reg.res;
	assign status_o = s_reg.status;
	assign pulse_o = s_reg.pulse;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_io_issue;
		accept && (ins_i.op == set_io_bit_op || ins_i.op == clear_io_bit_op);
	endsequence

	sequence s_io_write;
		mem_wr_en && !ready_o && mem_wr_addr == $past(ins_i.io_addr)
			&& mem_wr_data[$past(ins_i.bsel)] == ($past(ins_i.op) == set_io_bit_op);
	endsequence

	a_io_bit_two: assert property (s_io_issue |=> s_io_write ##1 ready_o && !res_o.valid)
		else $error("io bit op did not finish in two cycles");

	a_io_bit_flags: assert property (s_io_issue ##1 !bus_wr_i |=> status_o == $past(status_o, 2))
		else $error("io bit op changed status");

	a_shift_left: assert property (accept && ins_i.op == logical_left_shift_op
		|=> res_o.valid && res_o.data == {$past(ins_i.opd[6:0]), 1'b0}
			&& status_o[SR_C] == $past(ins_i.opd[7]) && status_o[SR_S] == $past(status_o[SR_S]))
		else $error("left shift result or flags wrong");

	a_shift_arith: assert property (accept && ins_i.op == arith_right_shift_op
		|=> res_o.data == {$past(ins_i.opd[7]), $past(ins_i.opd[7:1])}
			&& status_o[SR_V] == (res_o.data[7] ^ status_o[SR_C])
			&& status_o[SR_Z] == (res_o.data == 8'h00))
		else $error("arithmetic shift result or flags wrong");

	a_rotate_left: assert property (accept && ins_i.op == rotate_left_carry_op
		|=> res_o.data == {$past(ins_i.opd[6:0]), $past(status_o[SR_C])}
			&& status_o[SR_C] == $past(ins_i.opd[7]))
		else $error("rotate left through carry wrong");

	a_rotate_right: assert property (accept && ins_i.op == rotate_right_carry_op
		|=> res_o.data == {$past(status_o[SR_C]), $past(ins_i.opd[7:1])}
			&& status_o[SR_C] == $past(ins_i.opd[0]))
		else $error("rotate right through carry wrong");

	a_bit_store: assert property (accept && ins_i.op == bit_to_transfer_op
		|=> status_o[SR_T] == $past(ins_i.opd[ins_i.bsel])
			&& (status_o & 8'hbf) == ($past(status_o) & 8'hbf) && !res_o.valid)
		else $error("bit store wrong");

	a_bit_load: assert property (accept && ins_i.op == transfer_to_bit_op
		|=> res_o.data[$past(ins_i.bsel)] == $past(status_o[SR_T]) && status_o == $past(status_o))
		else $error("bit load wrong");

	a_flag_index: assert property (accept && ins_i.op == indexed_flag_set_op
		|=> status_o == ($past(status_o) | 8'(8'h01 << $past(ins_i.bsel))))
		else $error("indexed flag set wrong");

	a_flag_signed_ovf: assert property (accept && ft.hit
		|=> status_o[$past(ft.idx)] == $past(ft.val)
			&& ready_o)
		else $error("dedicated flag op wrong");

	a_ctrl_pulses: assert property (accept && ins_i.op == watchdog_kick_op
		|=> pulse_o.wdt_kick && status_o == $past(status_o) ##1 !pulse_o.wdt_kick)
		else $error("watchdog kick pulse wrong");

	a_swap_nibble: assert property (accept && ins_i.op == swap_nibbles_op
		|=> res_o.data == {$past(ins_i.opd[3:0]), $past(ins_i.opd[7:4])} && status_o == $past(status_o))
		else $error("swap wrong");

endmodule

// [test/test_bfx_exec_unit.sv]
// self-checking bench of the bit and flag execution unit
module test_bfx_exec_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import bfx_pkg::*;

	// ****************************************
	// signals and case table
	// ****************************************
	typedef struct {
		bfx_op_t op;
		logic [7:0] opd;
		logic [2:0] bsel;
		logic [7:0] st;
		logic v;
		logic [7:0] d;
		logic [7:0] s;
		logic [2:0] p;
	} bfx_tb_row_t;

	logic clock_i;
	logic rst_n_i;
	bfx_ins_t ins_i;
	logic ready_o;
	bfx_res_t res_o;
	logic [7:0] status_o;
	bfx_pulse_t pulse_o;
	logic [7:0] bus_addr_i;
	logic [7:0] bus_wdata_i;
	logic bus_wr_i;
	logic bus_rd_i;
	logic [7:0] bus_rdata_o;
	int errors;
	int check_count;
	logic [7:0] rd;
	int fidx [8] = '{SR_C, SR_N, SR_Z, SR_H, SR_T, SR_I, SR_S, SR_V};
	// pulse column: sleep, watchdog kick, break
	bfx_tb_row_t rows [16] = '{
		'{logical_left_shift_op, 8'h80, 3'h0, 8'h00, 1'b1, 8'h00, 8'h0b, 3'h0},
		'{logical_left_shift_op, 8'h41, 3'h0, 8'hff, 1'b1, 8'h82, 8'hfc, 3'h0},
		'{logical_right_shift_op, 8'h01, 3'h0, 8'h00, 1'b1, 8'h00, 8'h0b, 3'h0},
		'{logical_right_shift_op, 8'h80, 3'h0, 8'hff, 1'b1, 8'h40, 8'hf0, 3'h0},
		'{arith_right_shift_op, 8'h81, 3'h0, 8'h00, 1'b1, 8'hc0, 8'h05, 3'h0},
		'{rotate_left_carry_op, 8'h81, 3'h0, 8'h00, 1'b1, 8'h02, 8'h09, 3'h0},
		'{rotate_right_carry_op, 8'h02, 3'h0, 8'h01, 1'b1, 8'h81, 8'h0c, 3'h0},
		'{swap_nibbles_op, 8'h3c, 3'h0, 8'ha5, 1'b1, 8'hc3, 8'ha5, 3'h0},
		'{bit_to_transfer_op, 8'h08, 3'h3, 8'h00, 1'b0, 8'h00, 8'h40, 3'h0},
		'{bit_to_transfer_op, 8'hf7, 3'h3, 8'hff, 1'b0, 8'h00, 8'hbf, 3'h0},
		'{transfer_to_bit_op, 8'h00, 3'h7, 8'h40, 1'b1, 8'h80, 8'h40, 3'h0},
		'{transfer_to_bit_op, 8'hff, 3'h0, 8'hbf, 1'b1, 8'hfe, 8'hbf, 3'h0},
		'{nop_op, 8'hff, 3'h0, 8'h5a, 1'b0, 8'h00, 8'h5a, 3'h0},
		'{sleep_op, 8'hff, 3'h0, 8'ha5, 1'b0, 8'h00, 8'ha5, 3'h4},
		'{watchdog_kick_op, 8'hff, 3'h0, 8'h5a, 1'b0, 8'h00, 8'h5a, 3'h2},
		'{break_op, 8'hff, 3'h0, 8'hff, 1'b0, 8'h00, 8'hff, 3'h1}
	};

	bfx_exec_unit u_bfx_exec_unit (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ins_i(ins_i),
		.ready_o(ready_o),
		.res_o(res_o),
		.status_o(status_o),
		.pulse_o(pulse_o),
		.bus_addr_i(bus_addr_i),
		.bus_wdata_i(bus_wdata_i),
		.bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i),
		.bus_rdata_o(bus_rdata_o)
	);

	always #50 clock_i = ~clock_i;

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
		begin
			$display("All tests passed");
		end
		else
		begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		bus_wr_i <= 1'b1;
		bus_addr_i <= a;
		bus_wdata_i <= d;
		@(posedge clock_i);
		bus_wr_i <= 1'b0;
	endtask

	// data sampled in the one cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		bus_rd_i <= 1'b1;
		bus_addr_i <= a;
		@(posedge clock_i);
		bus_rd_i <= 1'b0;
		#1;
		d = bus_rdata_o;
	endtask

	task automatic issue(input bfx_op_t op, input logic [7:0] opd, input logic [2:0] bsel, input logic [3:0] io);
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: op, bsel: bsel, io_addr: io, opd: opd};
		@(posedge clock_i);
		ins_i.valid <= 1'b0;
		#1;
	endtask

	task automatic flag_case(input bfx_op_t op, input logic [2:0] bsel, input logic [7:0] st, input logic [7:0] exp);
		bus_wr(ADDR_STATUS, st);
		issue(op, 8'h00, bsel, 4'h0);
		chk("flag_status", {1'b0, exp}, {1'b0, status_o});
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		ins_i = '0;
		bus_addr_i = 8'h00;
		bus_wdata_i = 8'h00;
		bus_wr_i = 1'b0;
		bus_rd_i = 1'b0;
		errors = 0;
		check_count = 0;
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		#1;
		chk("reset_status", {1'b0, STATUS_RST}, {1'b0, status_o});
		chk("reset_ready", 9'h1, {8'h00, ready_o});
		chk("reset_res", 9'h0, {8'h00, res_o.valid});
		chk("reset_pulse", 9'h0, {6'h00, pulse_o});
		bus_rd(ADDR_IO_BASE + 8'h03, rd);
		chk("reset_io", 9'h0, {1'b0, rd});
		// unmapped place: write ignored, read zero
		bus_wr(8'h05, 8'hff);
		bus_rd(8'h05, rd);
		chk("unmapped", 9'h0, {1'b0, rd});
		for (int i = 0; i < 16; i++)
		begin
			bus_wr(ADDR_STATUS, rows[i].st);
			issue(rows[i].op, rows[i].opd, rows[i].bsel, 4'h0);
			chk("res_valid", {8'h00, rows[i].v}, {8'h00, res_o.valid});
			if (rows[i].v)
			begin
				chk("res_data", {1'b0, rows[i].d}, {1'b0, res_o.data});
			end
			chk("status", {1'b0, rows[i].s}, {1'b0, status_o});
			chk("pulse", {6'h00, rows[i].p}, {6'h00, pulse_o});
		end
		for (int k = 0; k < 8; k++)
		begin
			flag_case(bfx_op_t'(5'h10 + 5'(2 * k)), 3'h0, 8'h00, 8'h01 << fidx[k]);
			flag_case(bfx_op_t'(5'h11 + 5'(2 * k)), 3'h0, 8'hff, ~(8'h01 << fidx[k]));
			flag_case(indexed_flag_set_op, 3'(k), 8'h00, 8'h01 << k);
			flag_case(indexed_flag_clear_op, 3'(k), 8'hff, ~(8'h01 << k));
		end
		bus_rd(ADDR_STATUS, rd);
		// last flag case cleared bit 7 out of an all-ones status
		chk("status_read", 9'h07f, {1'b0, rd});
		@(posedge clock_i);
		#1;
		chk("rdata_idle", 9'h0, {1'b0, bus_rdata_o});
		// back to back rotates: second must see the carry left by the first
		bus_wr(ADDR_STATUS, 8'h00);
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: rotate_left_carry_op, bsel: 3'h0, io_addr: 4'h0, opd: 8'h81};
		@(posedge clock_i);
		ins_i.opd <= 8'h02;
		#1;
		chk("rol_first", 9'h102, {res_o.valid, res_o.data});
		@(posedge clock_i);
		ins_i.valid <= 1'b0;
		#1;
		chk("rol_second", 9'h105, {res_o.valid, res_o.data});
		chk("rol_status", 9'h000, {1'b0, status_o});
		// io bit ops: second cycle busy, a request then is dropped
		bus_wr(ADDR_STATUS, 8'ha5);
		bus_wr(ADDR_IO_BASE + 8'h03, 8'h0f);
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: set_io_bit_op, bsel: 3'h6, io_addr: 4'h3, opd: 8'h00};
		@(posedge clock_i);
		ins_i.bsel <= 3'h7;
		#1;
		chk("io_busy", 9'h0, {8'h00, ready_o});
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: clear_io_bit_op, bsel: 3'h0, io_addr: 4'h3, opd: 8'h00};
		#1;
		chk("io_ready", 9'h1, {8'h00, ready_o});
		@(posedge clock_i);
		ins_i.valid <= 1'b0;
		#1;
		chk("io_busy2", 9'h0, {8'h00, ready_o});
		@(posedge clock_i);
		bus_rd(ADDR_IO_BASE + 8'h03, rd);
		chk("io_word", 9'h04e, {1'b0, rd});
		chk("io_status", 9'h0a5, {1'b0, status_o});
		// software io write in the write-back cycle: dropped, sticky collide set
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: set_io_bit_op, bsel: 3'h0, io_addr: 4'h3, opd: 8'h00};
		@(posedge clock_i);
		ins_i.valid <= 1'b0;
		bus_wr_i <= 1'b1;
		bus_addr_i <= ADDR_IO_BASE + 8'h03;
		bus_wdata_i <= 8'hff;
		@(posedge clock_i);
		bus_wr_i <= 1'b0;
		bus_rd_i <= 1'b1;
		bus_addr_i <= ADDR_INFO;
		@(posedge clock_i);
		bus_rd_i <= 1'b0;
		#1;
		chk("info_collide", 9'h002, {1'b0, bus_rdata_o});
		bus_rd(ADDR_IO_BASE + 8'h03, rd);
		chk("io_kept", 9'h04f, {1'b0, rd});
		bus_wr(ADDR_INFO, 8'h02);
		bus_rd(ADDR_INFO, rd);
		chk("info_clear", 9'h000, {1'b0, rd});
		// busy bit seen by a read strobe taken at the write-back edge
		@(posedge clock_i);
		ins_i <= '{valid: 1'b1, op: clear_io_bit_op, bsel: 3'h0, io_addr: 4'h3, opd: 8'h00};
		@(posedge clock_i);
		ins_i.valid <= 1'b0;
		bus_rd_i <= 1'b1;
		bus_addr_i <= ADDR_INFO;
		@(posedge clock_i);
		bus_rd_i <= 1'b0;
		#1;
		chk("info_busy", 9'h001, {1'b0, bus_rdata_o});
		bus_rd(ADDR_IO_BASE + 8'h03, rd);
		chk("io_cleared", 9'h04e, {1'b0, rd});
		end_sim;
	end

	// generous bound: the sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clock_i);
		errors++;
		end_sim;
	end
endmodule
